//--- override_hold.sv
`timescale 1ns/1ps
module override_hold
	import strap_option_pkg::*;
#(
	parameter int            W       = 1,
	parameter logic [W-1:0]  RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	// Strap capture
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_load_val,
	// Software field write
	input  wire logic         i_wr,
	input  wire logic [W-1:0] i_wr_val,
	// Held setting
	output logic      [W-1:0] o_q
);

	logic [W-1:0] hold_ff;
	logic [W-1:0] nxt_hold;

	// Software write wins over a coincident capture: it is the newer intent
	always_comb begin
		nxt_hold = hold_ff;
		if (i_wr) begin
			nxt_hold = i_wr_val;
		end else if (i_load) begin
			nxt_hold = i_load_val;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			hold_ff <= RST_VAL;
		end else begin
			hold_ff <= nxt_hold;
		end
	end

	assign o_q = hold_ff;

endmodule

//--- strap_board_model.sv
`timescale 1ns/1ps
module strap_board_model
	import strap_option_pkg::*;
(
	// Clock and capture status
	input  wire logic        i_mclk,
	input  wire logic        i_captured,
	// Planned levels
	input  wire strap_pins_t i_plan,
	// Strap pins
	output strap_pins_t      o_pins
);
	strap_pins_t legal;

	always_comb begin
		legal = i_plan;
		legal.sec_pd = i_plan.sec_pd | ~i_plan.lane_mode;
	end

	// Once captured, pins wander every cycle to expose any late sampling
	always @(negedge i_mclk) begin
		if (!i_captured) begin
			o_pins <= legal;
		end else begin
			o_pins <= ~o_pins;
		end
	end
endmodule

//--- strap_option_latch.sv
`timescale 1ns/1ps
module strap_option_latch
	import strap_option_pkg::*;
(
	// Clock and reset
	input  wire logic                             i_mclk,
	input  wire logic                             i_rst,
	// Strap pins
	input  wire strap_pins_t                      i_straps,
	// Lane-mode field writes
	input  wire logic [NUM_PAIRS-1:0]             i_mac_lane_mode_wr,
	input  wire logic [NUM_PAIRS-1:0]             i_mac_lane_mode_field,
	// Port width override writes
	input  wire logic [NUM_PAIRS-1:0]             i_port_width_override_wr,
	input  wire logic [NUM_PAIRS-1:0]             i_port_width_override_field,
	// Lane rate field writes
	input  wire logic [NUM_PAIRS-1:0]             i_lane_rate_wr,
	input  wire logic [NUM_PAIRS-1:0][RATE_W-1:0] i_lane_rate_field,
	// Power-down field writes
	input  wire logic [NUM_PAIRS-1:0]             i_wide_port_powerdown_wr,
	input  wire logic [NUM_PAIRS-1:0]             i_wide_port_powerdown_field,
	input  wire logic [NUM_PAIRS-1:0]             i_narrow_port_powerdown_wr,
	input  wire logic [NUM_PAIRS-1:0]             i_narrow_port_powerdown_field,
	// Lane reverse field writes
	input  wire logic [NUM_WIDE-1:0]              i_rx_reverse_wr,
	input  wire logic [NUM_WIDE-1:0]              i_rx_reverse_field,
	input  wire logic [NUM_WIDE-1:0]              i_tx_reverse_wr,
	input  wire logic [NUM_WIDE-1:0]              i_tx_reverse_field,
	// Capture status
	output logic                                  o_config_valid,
	output logic                                  o_rate_strap_illegal,
	// Per-pair configuration
	output logic [NUM_PAIRS-1:0]                  o_pair_mode,
	output logic [NUM_PAIRS-1:0]                  o_port_width,
	output logic [NUM_PAIRS-1:0][RATE_W-1:0]      o_lane_rate,
	output logic [NUM_PAIRS-1:0]                  o_primary_pd,
	output logic [NUM_PAIRS-1:0]                  o_secondary_pd,
	output logic [NUM_PAIRS-1:0]                  o_pd_conflict,
	// Wide port lane order
	output logic [NUM_WIDE-1:0]                   o_rx_reverse,
	output logic [NUM_WIDE-1:0]                   o_tx_reverse,
	// EEPROM boot settings
	output eeprom_cfg_t                           o_eeprom_cfg,
	output logic                                  o_boot_load_req
);

	//------------------------------------------------------------
	// Decoding helpers
	//------------------------------------------------------------
	function automatic logic [SA_W-1:0] boot_low_bits(input logic sel, input logic [SA_W-1:0] sa);
		boot_low_bits = sel ? sa : BOOT_LOW_DFLT;
	endfunction

	function automatic logic second_pd(input logic pri, input logic sec);
		second_pd = (pri == PD_DOWN) ? PD_DOWN : sec;
	endfunction

	function automatic int wide_pair(input int idx);
		wide_pair = (idx == 0) ? WIDE_PAIR0 : WIDE_PAIR1;
	endfunction

	//------------------------------------------------------------
	// Pin synchronisation
	//------------------------------------------------------------
	logic [STRAP_W-1:0] strap_sync_bits;
	strap_pins_t        straps_s;

	strap_sync #(
		.W (STRAP_W)
	) u_sync (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_async (i_straps),
		.o_sync  (strap_sync_bits)
	);

	assign straps_s = strap_pins_t'(strap_sync_bits);

	//------------------------------------------------------------
	// Capture sequencer
	//------------------------------------------------------------
	// Sampling at the last settle edge sees pins from two edges earlier,
	// still inside the window the board keeps steady.
	capture_state_t state_ff;
	capture_state_t nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic             load;

	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		load      = 1'b0;
		case (state_ff)
			ST_SETTLE: begin
				if (cnt_ff == CNT_LAST) begin
					load      = 1'b1;
					nxt_state = ST_HELD;
				end else begin
					nxt_cnt = cnt_ff + CNT_ONE;
				end
			end
			ST_HELD: begin
				nxt_state = ST_HELD;
			end
			default: begin
				nxt_state = ST_SETTLE;
				nxt_cnt   = '0;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_ff <= ST_SETTLE;
			cnt_ff   <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	//------------------------------------------------------------
	// Per-pair holding registers
	//------------------------------------------------------------
	logic [NUM_PAIRS-1:0] sec_pd_strap;

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PAIRS; gp++) begin : g_pair
			assign sec_pd_strap[gp] = second_pd(straps_s.pri_pd[gp], straps_s.sec_pd[gp]);

			// Mode and width seed from one strap but are written separately
			// Mode field takes over once written
			override_hold #(
				.W       (1),
				.RST_VAL (RST_MODE)
			) u_mode (
				.i_mclk     (i_mclk),
				.i_rst      (i_rst),
				.i_load     (load),
				.i_load_val (straps_s.lane_mode[gp]),
				.i_wr       (i_mac_lane_mode_wr[gp]),
				.i_wr_val   (i_mac_lane_mode_field[gp]),
				.o_q        (o_pair_mode[gp])
			);

			override_hold #(
				.W       (1),
				.RST_VAL (RST_MODE)
			) u_width (
				.i_mclk     (i_mclk),
				.i_rst      (i_rst),
				.i_load     (load),
				.i_load_val (straps_s.lane_mode[gp]),
				.i_wr       (i_port_width_override_wr[gp]),
				.i_wr_val   (i_port_width_override_field[gp]),
				.o_q        (o_port_width[gp])
			);

			override_hold #(
				.W       (RATE_W),
				.RST_VAL (RST_RATE)
			) u_rate (
				.i_mclk     (i_mclk),
				.i_rst      (i_rst),
				.i_load     (load),
				.i_load_val (straps_s.lane_rate),
				.i_wr       (i_lane_rate_wr[gp]),
				.i_wr_val   (i_lane_rate_field[gp]),
				.o_q        (o_lane_rate[gp])
			);

			override_hold #(
				.W       (1),
				.RST_VAL (RST_PD)
			) u_pri_pd (
				.i_mclk     (i_mclk),
				.i_rst      (i_rst),
				.i_load     (load),
				.i_load_val (straps_s.pri_pd[gp]),
				.i_wr       (i_wide_port_powerdown_wr[gp]),
				.i_wr_val   (i_wide_port_powerdown_field[gp]),
				.o_q        (o_primary_pd[gp])
			);

			override_hold #(
				.W       (1),
				.RST_VAL (RST_PD)
			) u_sec_pd (
				.i_mclk     (i_mclk),
				.i_rst      (i_rst),
				.i_load     (load),
				.i_load_val (sec_pd_strap[gp]),
				.i_wr       (i_narrow_port_powerdown_wr[gp]),
				.i_wr_val   (i_narrow_port_powerdown_field[gp]),
				.o_q        (o_secondary_pd[gp])
			);
		end
	endgenerate

	//------------------------------------------------------------
	// Wide port lane order
	//------------------------------------------------------------
	genvar gw;
	generate
		for (gw = 0; gw < NUM_WIDE; gw++) begin : g_wide
			// One strap per direction seeds both wide ports
			override_hold #(
				.W       (1),
				.RST_VAL (ORDER_ABCD)
			) u_rx_rev (
				.i_mclk     (i_mclk),
				.i_rst      (i_rst),
				.i_load     (load),
				.i_load_val (straps_s.rx_reverse),
				.i_wr       (i_rx_reverse_wr[gw]),
				.i_wr_val   (i_rx_reverse_field[gw]),
				.o_q        (o_rx_reverse[gw])
			);

			override_hold #(
				.W       (1),
				.RST_VAL (ORDER_ABCD)
			) u_tx_rev (
				.i_mclk     (i_mclk),
				.i_rst      (i_rst),
				.i_load     (load),
				.i_load_val (straps_s.tx_reverse),
				.i_wr       (i_tx_reverse_wr[gw]),
				.i_wr_val   (i_tx_reverse_field[gw]),
				.o_q        (o_tx_reverse[gw])
			);
		end
	endgenerate

	//------------------------------------------------------------
	// EEPROM boot settings and status
	//------------------------------------------------------------
	eeprom_cfg_t          eeprom_ff;
	eeprom_cfg_t          nxt_eeprom;
	logic                 valid_ff;
	logic                 nxt_valid;
	logic                 illegal_ff;
	logic                 nxt_illegal;
	logic                 boot_req_ff;
	logic                 nxt_boot_req;
	logic [NUM_PAIRS-1:0] conflict_ff;
	logic [NUM_PAIRS-1:0] nxt_conflict;

	always_comb begin
		nxt_eeprom   = eeprom_ff;
		nxt_valid    = valid_ff;
		nxt_illegal  = illegal_ff;
		nxt_boot_req = 1'b0;
		if (load) begin
			nxt_eeprom.multi_byte  = straps_s.addr_width;
			nxt_eeprom.slave_low   = straps_s.slave_low;
			nxt_eeprom.boot_low    = boot_low_bits(straps_s.boot_addr_sel,
				straps_s.slave_low);
			nxt_eeprom.boot_enable = ~straps_s.boot_disable;
			// Single-cycle request for the boot engine to latch
			nxt_boot_req           = ~straps_s.boot_disable;
			nxt_valid              = 1'b1;
			// Code 11 is kept and flagged so the board fault stays visible
			nxt_illegal            = (straps_s.lane_rate == RATE_ILLEGAL);
		end
		// Flags a 4x pair whose unused port is still powered up
		// Advisory only, one cycle behind the outputs; gates nothing
		for (int i = 0; i < NUM_PAIRS; i++) begin
			nxt_conflict[i] = valid_ff && (o_pair_mode[i] == MODE_WIDE)
				&& (o_secondary_pd[i] == PD_UP);
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			eeprom_ff   <= '0;
			valid_ff    <= 1'b0;
			illegal_ff  <= 1'b0;
			boot_req_ff <= 1'b0;
			conflict_ff <= '0;
		end else begin
			eeprom_ff   <= nxt_eeprom;
			valid_ff    <= nxt_valid;
			illegal_ff  <= nxt_illegal;
			boot_req_ff <= nxt_boot_req;
			conflict_ff <= nxt_conflict;
		end
	end

	assign o_eeprom_cfg         = eeprom_ff;
	assign o_config_valid       = valid_ff;
	assign o_rate_strap_illegal = illegal_ff;
	assign o_boot_load_req      = boot_req_ff;
	assign o_pd_conflict        = conflict_ff;

endmodule

//--- strap_option_latch_bench.sv
`timescale 1ns/1ps
module strap_option_latch_bench
	import strap_option_pkg::*;
;
	typedef struct packed {
		logic [NUM_PAIRS-1:0]             mode, width, ppd, spd;
		logic [NUM_PAIRS-1:0][RATE_W-1:0] rate;
		logic [NUM_WIDE-1:0]              rx, tx;
		eeprom_cfg_t                      ee;
		logic                             ill;
	} snap_t;

	logic                             i_mclk = 1'b0;
	logic                             i_rst = 1'b1;
	strap_pins_t                      straps, plan = '0;
	logic [NUM_PAIRS-1:0]             mode_wr = '0, mode_f = '0, width_wr = '0, width_f = '0;
	logic [NUM_PAIRS-1:0]             wide_wr = '0, wide_f = '0, narr_wr = '0, narr_f = '0, rate_wr = '0;
	logic [NUM_PAIRS-1:0][RATE_W-1:0] rate_f = '0;
	logic [NUM_WIDE-1:0]              rx_wr = '0, rx_f = '0, tx_wr = '0, tx_f = '0;
	logic [63:0]                      rnd;
	logic                             valid, boot_req, wr_seen = 1'b0, prev_valid = 1'b0, exp_boot;
	snap_t                            act, exp_s, q[$];
	int                               n_mismatch = 0;
	int                               cmp_count = 0;

	initial forever #50 i_mclk = ~i_mclk;

	strap_option_latch i_dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_straps(straps),
		.i_mac_lane_mode_wr(mode_wr), .i_mac_lane_mode_field(mode_f),
		.i_port_width_override_wr(width_wr), .i_port_width_override_field(width_f),
		.i_lane_rate_wr(rate_wr), .i_lane_rate_field(rate_f),
		.i_wide_port_powerdown_wr(wide_wr), .i_wide_port_powerdown_field(wide_f),
		.i_narrow_port_powerdown_wr(narr_wr), .i_narrow_port_powerdown_field(narr_f),
		.i_rx_reverse_wr(rx_wr), .i_rx_reverse_field(rx_f), .i_tx_reverse_wr(tx_wr), .i_tx_reverse_field(tx_f),
		.o_config_valid(valid), .o_rate_strap_illegal(act.ill), .o_pair_mode(act.mode),
		.o_port_width(act.width), .o_lane_rate(act.rate), .o_primary_pd(act.ppd), .o_secondary_pd(act.spd),
		.o_pd_conflict(), .o_rx_reverse(act.rx), .o_tx_reverse(act.tx), .o_eeprom_cfg(act.ee),
		.o_boot_load_req(boot_req)
	);

	strap_board_model i_board (.i_mclk(i_mclk), .i_captured(valid), .i_plan(plan), .o_pins(straps));

	//----------------------------------------
	// Compare and close
	//----------------------------------------
	task automatic cmp_snap(input snap_t e, input snap_t a);
		cmp_count++;
		if (a !== e) begin
			n_mismatch++;
			$display("unexpected settings at %0t: exp %h got %h", $time, e, a);
		end
	endtask

	task automatic cmp_bit(input logic e, input logic a);
		cmp_count++;
		if (a !== e) begin
			n_mismatch++;
			$display("unexpected flag at %0t: exp %h got %h", $time, e, a);
		end
	endtask

	task test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	function automatic snap_t capture(input strap_pins_t s);
		capture.mode = s.lane_mode;
		capture.width = s.lane_mode;
		capture.ppd = s.pri_pd;
		capture.spd = s.pri_pd | s.sec_pd;
		capture.rate = {NUM_PAIRS{s.lane_rate}};
		capture.rx = {NUM_WIDE{s.rx_reverse}};
		capture.tx = {NUM_WIDE{s.tx_reverse}};
		capture.ee = {s.addr_width, s.slave_low, (s.boot_addr_sel ? s.slave_low : BOOT_LOW_DFLT), ~s.boot_disable};
		capture.ill = (s.lane_rate == RATE_ILLEGAL);
	endfunction

	//----------------------------------------
	// Monitor
	//----------------------------------------
	always @(posedge i_mclk) wr_seen <= |{mode_wr, width_wr, rate_wr, wide_wr, narr_wr, rx_wr, tx_wr};

	always @(negedge i_mclk) begin
		if (valid === 1'b1 && !prev_valid) begin
			cmp_bit(exp_boot, boot_req);
			cmp_snap(q.pop_front(), act);
		end else if (wr_seen) begin
			cmp_snap(q.pop_front(), act);
		end
		prev_valid = (valid === 1'b1);
	end

	//----------------------------------------
	// Stimulus
	//----------------------------------------
	initial begin
		void'($urandom(32'hed5a_5847));
		for (int it = 0; it < 4; it++) begin
			i_rst = 1'b1;
			plan = strap_pins_t'($urandom);
			plan.lane_rate = it[1:0];
			exp_s = capture(plan);
			exp_s.spd = exp_s.spd | ~plan.lane_mode;
			exp_boot = ~plan.boot_disable;
			q.push_back(exp_s);
			repeat (4) @(negedge i_mclk);
			i_rst = 1'b0;
			repeat (9) @(negedge i_mclk);
			cmp_bit(1'b0, valid);
			@(negedge i_mclk);
			cmp_bit(1'b1, valid);
			repeat (12) begin
				rnd = {$urandom, $urandom};
				{mode_wr, mode_f, width_wr, width_f, wide_wr, wide_f, narr_wr, narr_f} = rnd[31:0];
				{rate_wr, rx_wr, rx_f, tx_wr, tx_f} = rnd[43:32];
				for (int p = 0; p < NUM_PAIRS; p++) begin
					rate_f[p] = RATE_W'($urandom_range(2));
					if (rate_wr[p]) exp_s.rate[p] = rate_f[p];
				end
				exp_s.mode = (exp_s.mode & ~mode_wr) | (mode_f & mode_wr);
				exp_s.width = (exp_s.width & ~width_wr) | (width_f & width_wr);
				exp_s.ppd = (exp_s.ppd & ~wide_wr) | (wide_f & wide_wr);
				exp_s.spd = (exp_s.spd & ~narr_wr) | (narr_f & narr_wr);
				exp_s.rx = (exp_s.rx & ~rx_wr) | (rx_f & rx_wr);
				exp_s.tx = (exp_s.tx & ~tx_wr) | (tx_f & tx_wr);
				if (|{mode_wr, width_wr, rate_wr, wide_wr, narr_wr, rx_wr, tx_wr}) q.push_back(exp_s);
				@(negedge i_mclk);
			end
			{mode_wr, width_wr, rate_wr, wide_wr, narr_wr, rx_wr, tx_wr} = '0;
			repeat (3) @(negedge i_mclk);
		end
		test_done();
	end

	initial begin
		repeat (3000) @(posedge i_mclk);
		n_mismatch++;
		$display("unexpected timeout at %0t: exp %h got %h", $time, 1'b1, 1'b0);
		test_done();
	end
endmodule

bind strap_option_latch strap_option_props i_props (
	.i_mclk, .i_rst, .i_straps, .i_mac_lane_mode_wr, .i_mac_lane_mode_field, .i_lane_rate_wr,
	.i_lane_rate_field, .i_wide_port_powerdown_wr, .i_wide_port_powerdown_field, .o_config_valid,
	.o_rate_strap_illegal, .o_pair_mode, .o_lane_rate, .o_primary_pd, .o_secondary_pd, .o_pd_conflict,
	.o_eeprom_cfg, .o_boot_load_req
);

//--- strap_option_pkg.sv
package strap_option_pkg;

	//------------------------------------------------------------
	// Structure
	//------------------------------------------------------------
	localparam int NUM_PAIRS  = 4;
	localparam int NUM_WIDE   = 2;
	localparam int WIDE_PAIR0 = 0;
	localparam int WIDE_PAIR1 = 3;
	localparam int RATE_W     = 2;
	localparam int SA_W       = 2;

	//------------------------------------------------------------
	// Timing
	//------------------------------------------------------------
	localparam int SETTLE_CYCLES = 10;
	localparam int CNT_W         = 4;

	//------------------------------------------------------------
	// Encodings and reset values
	//------------------------------------------------------------
	localparam logic [RATE_W-1:0] RATE_1G25    = 2'h0;
	localparam logic [RATE_W-1:0] RATE_2G5     = 2'h1;
	localparam logic [RATE_W-1:0] RATE_3G125   = 2'h2;
	localparam logic [RATE_W-1:0] RATE_ILLEGAL = 2'h3;
	localparam logic              MODE_WIDE    = 1'h0;
	localparam logic              MODE_NARROW  = 1'h1;
	localparam logic              PD_UP        = 1'h0;
	localparam logic              PD_DOWN      = 1'h1;
	localparam logic              ORDER_ABCD   = 1'h0;
	localparam logic [SA_W-1:0]   BOOT_LOW_DFLT = 2'h0;

	localparam logic              RST_MODE = MODE_NARROW;
	localparam logic [RATE_W-1:0] RST_RATE = RATE_3G125;
	localparam logic              RST_PD   = PD_DOWN;

	//------------------------------------------------------------
	// Carriers
	//------------------------------------------------------------
	typedef struct packed {
		logic [NUM_PAIRS-1:0] lane_mode;
		logic [RATE_W-1:0]    lane_rate;
		logic [NUM_PAIRS-1:0] pri_pd;
		logic [NUM_PAIRS-1:0] sec_pd;
		logic                 rx_reverse;
		logic                 tx_reverse;
		logic                 addr_width;
		logic [SA_W-1:0]      slave_low;
		logic                 boot_addr_sel;
		logic                 boot_disable;
	} strap_pins_t;

	localparam int STRAP_W = $bits(strap_pins_t);

	typedef struct packed {
		logic                 multi_byte;
		logic [SA_W-1:0]      slave_low;
		logic [SA_W-1:0]      boot_low;
		logic                 boot_enable;
	} eeprom_cfg_t;

	typedef enum logic [0:0] {
		ST_SETTLE,
		ST_HELD
	} capture_state_t;

endpackage

//--- strap_option_props.sv
`timescale 1ns/1ps
module strap_option_props
	import strap_option_pkg::*;
(
	// Clock and reset
	input wire logic                             i_mclk,
	input wire logic                             i_rst,
	// Inputs
	input wire strap_pins_t                      i_straps,
	input wire logic [NUM_PAIRS-1:0]             i_mac_lane_mode_wr,
	input wire logic [NUM_PAIRS-1:0]             i_mac_lane_mode_field,
	input wire logic [NUM_PAIRS-1:0]             i_lane_rate_wr,
	input wire logic [NUM_PAIRS-1:0][RATE_W-1:0] i_lane_rate_field,
	input wire logic [NUM_PAIRS-1:0]             i_wide_port_powerdown_wr,
	input wire logic [NUM_PAIRS-1:0]             i_wide_port_powerdown_field,
	// Outputs
	input wire logic                             o_config_valid,
	input wire logic                             o_rate_strap_illegal,
	input wire logic [NUM_PAIRS-1:0]             o_pair_mode,
	input wire logic [NUM_PAIRS-1:0][RATE_W-1:0] o_lane_rate,
	input wire logic [NUM_PAIRS-1:0]             o_primary_pd,
	input wire logic [NUM_PAIRS-1:0]             o_secondary_pd,
	input wire logic [NUM_PAIRS-1:0]             o_pd_conflict,
	input wire eeprom_cfg_t                      o_eeprom_cfg,
	input wire logic                             o_boot_load_req
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	// Saturates so it never wraps back into the settle window
	always_comb begin
		nxt_cnt = (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
	end
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	valid_timing_a: assert property (o_config_valid == (cnt_ff >= SETTLE_CYCLES))
		else $error("config valid at wrong cycle");
	mode_hold_a: assert property (o_config_valid && !(|i_mac_lane_mode_wr) |=> $stable(o_pair_mode))
		else $error("pair mode moved without a write");
	mode_write_a: assert property (|i_mac_lane_mode_wr |=>
		((o_pair_mode ^ $past(i_mac_lane_mode_field)) & $past(i_mac_lane_mode_wr)) == '0)
		else $error("mode field write not applied");
	rate_write_a: assert property (i_lane_rate_wr[0] |=> o_lane_rate[0] == $past(i_lane_rate_field[0]))
		else $error("rate field write not applied");
	pd_write_a: assert property (i_wide_port_powerdown_wr[0] |=>
		o_primary_pd[0] == $past(i_wide_port_powerdown_field[0]))
		else $error("power-down write not applied");
	cap_rate_a: assert property ($rose(o_config_valid) |->
		o_lane_rate == {NUM_PAIRS{$past(i_straps.lane_rate, 3)}}
		&& o_rate_strap_illegal == ($past(i_straps.lane_rate, 3) == RATE_ILLEGAL))
		else $error("captured rate wrong");
	cap_pd_a: assert property ($rose(o_config_valid) |-> o_primary_pd == $past(i_straps.pri_pd, 3)
		&& o_secondary_pd == ($past(i_straps.pri_pd, 3) | $past(i_straps.sec_pd, 3)))
		else $error("captured power-down wrong");
	cap_mode_a: assert property ($rose(o_config_valid) |-> o_pair_mode == $past(i_straps.lane_mode, 3))
		else $error("captured lane mode wrong");
	cap_eeprom_a: assert property ($rose(o_config_valid) |->
		o_eeprom_cfg == {$past(i_straps.addr_width, 3), $past(i_straps.slave_low, 3),
		($past(i_straps.boot_addr_sel, 3) ? $past(i_straps.slave_low, 3) : BOOT_LOW_DFLT),
		!$past(i_straps.boot_disable, 3)})
		else $error("captured eeprom settings wrong");
	boot_pulse_a: assert property (o_boot_load_req |-> $rose(o_config_valid) ##1 !o_boot_load_req)
		else $error("boot request not a single capture pulse");
	boot_value_a: assert property ($rose(o_config_valid) |-> o_boot_load_req == !$past(i_straps.boot_disable, 3))
		else $error("boot request disagrees with strap");
	pd_conflict_a: assert property ($past(o_config_valid) |->
		o_pd_conflict == (~$past(o_pair_mode) & ~$past(o_secondary_pd)))
		else $error("conflict flag wrong");

	cover property (o_boot_load_req);
	cover property (o_pd_conflict != '0);
	cover property ($rose(o_config_valid) && o_rate_strap_illegal);
endmodule

//--- strap_sync.sv
`timescale 1ns/1ps
module strap_sync
	import strap_option_pkg::*;
#(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	// Pin side
	input  wire logic [W-1:0] i_async,
	// Core side
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	// First stage feeds only the second stage
	always_comb begin
		nxt_meta = i_async;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign o_sync = sync_ff;

endmodule
